// ---- hdl/rig_top.sv ----
`timescale 1ns/1ns
module rig_top #(
  parameter int DIV_W = 15
) (
  // Clock, reset, enable
  input wire logic SYS_CLK,
  input wire logic RESET_N,
  input wire logic CE,
  // Register port
  input wire rig_pkg::rig_req_t REG_REQ,
  output logic [7:0] REG_RDATA,
  // Event generators
  input wire logic TB_TICK,
  input wire logic ALARM_MATCH,
  input wire logic UPDATE_DONE,
  // Open-drain request pin, active low
  output logic IRQ_N_O,
  output logic IRQ_N_OE,
  // System interrupt
  output logic INT_LVL
);
  import rig_pkg::*;

  // ----------------------------------------------------------------
  // Elaboration checks
  // ----------------------------------------------------------------
  if (DIV_W < RIG_DIV_W) begin : g_bad_div
    $error("rig_top: DIV_W too small for slowest periodic rate");
  end

  // ----------------------------------------------------------------
  // Bus decode
  // ----------------------------------------------------------------
  logic wr_rate;
  logic wr_ctrl;
  logic wr_sts;
  logic wr_msk;
  logic rd_flag;

  assign wr_rate = REG_REQ.wr && (REG_REQ.addr == RIG_OFF_RATE);
  assign wr_ctrl = REG_REQ.wr && (REG_REQ.addr == RIG_OFF_CTRL);
  assign wr_sts = REG_REQ.wr && (REG_REQ.addr == RIG_OFF_STS);
  assign wr_msk = REG_REQ.wr && (REG_REQ.addr == RIG_OFF_MSK);
  assign rd_flag = REG_REQ.rd && (REG_REQ.addr == RIG_OFF_FLAG);

  // ----------------------------------------------------------------
  // Periodic divider
  // ----------------------------------------------------------------
  logic [DIV_W-1:0] div_q;
  logic [DIV_W-1:0] div_d;
  logic [DIV_W-1:0] per_mask;
  logic [DIV_W-1:0] one_w;
  logic [3:0] rate_q;
  logic [3:0] tap;
  logic per_hit;

  assign one_w = {{(DIV_W-1){1'b0}}, 1'b1};

  // Rates 1 and 2 alias onto the slow taps 7 and 8, those of rates 8 and 9; rates 3 and up use tap rate-1
  always_comb begin
    unique case (rate_q)
      4'h1: tap = RIG_TAP_RATE1;
      4'h2: tap = RIG_TAP_RATE2;
      default: tap = 4'(rate_q - 4'h1);
    endcase
    per_mask = (one_w << tap) - one_w;
    div_d = TB_TICK ? div_q + one_w : div_q;
    per_hit = TB_TICK && (rate_q != 4'h0) && ((div_q & per_mask) == per_mask);
  end

  always_ff @(posedge SYS_CLK) begin
    if (!RESET_N) begin
      div_q <= '0;
    end else if (CE) begin
      div_q <= div_d;
    end
  end

  // ----------------------------------------------------------------
  // Control registers
  // ----------------------------------------------------------------
  logic [3:0] rate_d;
  logic [7:0] ctrl_q;
  logic [7:0] ctrl_d;
  rig_ev_t en_d;
  rig_ev_t en_q;

  always_comb begin
    rate_d = wr_rate ? REG_REQ.wdata[3:0] : rate_q;
    ctrl_d = wr_ctrl ? REG_REQ.wdata : ctrl_q;
    // A frozen user copy during SET also holds back the update request
    en_d.periodic = ctrl_d[RIG_BIT_PIE];
    en_d.alarm = ctrl_d[RIG_BIT_AIE];
    en_d.update = ctrl_d[RIG_BIT_UIE] && !ctrl_d[RIG_BIT_SET];
    en_q.periodic = ctrl_q[RIG_BIT_PIE];
    en_q.alarm = ctrl_q[RIG_BIT_AIE];
    en_q.update = ctrl_q[RIG_BIT_UIE] && !ctrl_q[RIG_BIT_SET];
  end

  always_ff @(posedge SYS_CLK) begin
    if (!RESET_N) begin
      rate_q <= RIG_RATE_RST;
      ctrl_q <= RIG_CTRL_RST;
    end else if (CE) begin
      rate_q <= rate_d;
      ctrl_q <= ctrl_d;
    end
  end

  // ----------------------------------------------------------------
  // Event flags and request pin
  // ----------------------------------------------------------------
  rig_ev_t ev;
  rig_ev_t flags_q;
  rig_ev_t flags_d;
  rig_ev_t hold_q;
  rig_ev_t hold_d;
  logic irq_oe_q;
  logic irq_oe_d;

  always_comb begin
    ev.periodic = per_hit;
    ev.alarm = ALARM_MATCH;
    ev.update = UPDATE_DONE;
    // Events landing in the read cycle wait one cycle so the read sees stable flags
    if (rd_flag) begin
      flags_d = '0;
      // Older held events stay held, or a second read back to back would lose them
      hold_d = hold_q | ev;
    end else begin
      flags_d = flags_q | hold_q | ev;
      hold_d = '0;
    end
    irq_oe_d = |(flags_d & en_d);
  end

  always_ff @(posedge SYS_CLK) begin
    if (!RESET_N) begin
      flags_q <= '0;
      hold_q <= '0;
      irq_oe_q <= 1'b0;
    end else if (CE) begin
      flags_q <= flags_d;
      hold_q <= hold_d;
      irq_oe_q <= irq_oe_d;
    end
  end

  assign IRQ_N_O = 1'b0;
  assign IRQ_N_OE = irq_oe_q;

  // ----------------------------------------------------------------
  // System interrupt
  // ----------------------------------------------------------------
  logic [2:0] sts_q;
  logic [2:0] sts_d;
  logic [2:0] msk_q;
  logic [2:0] msk_d;
  logic int_q;
  logic int_d;

  always_comb begin
    msk_d = wr_msk ? REG_REQ.wdata[2:0] : msk_q;
    // New events win over a write-one-to-clear in the same cycle
    sts_d = (sts_q & ~(wr_sts ? REG_REQ.wdata[2:0] : 3'h0)) | ev;
    int_d = |(sts_d & msk_d);
  end

  always_ff @(posedge SYS_CLK) begin
    if (!RESET_N) begin
      sts_q <= '0;
      msk_q <= RIG_MSK_RST;
      int_q <= 1'b0;
    end else if (CE) begin
      sts_q <= sts_d;
      msk_q <= msk_d;
      int_q <= int_d;
    end
  end

  assign INT_LVL = int_q;

  // ----------------------------------------------------------------
  // Read data
  // ----------------------------------------------------------------
  logic [7:0] rdata_q;
  logic [7:0] rdata_d;

  always_comb begin
    rdata_d = 8'h00;
    if (REG_REQ.rd) begin
      unique case (REG_REQ.addr)
        RIG_OFF_RATE: rdata_d = {4'h0, rate_q};
        RIG_OFF_CTRL: rdata_d = ctrl_q;
        RIG_OFF_FLAG: rdata_d = {irq_oe_q, flags_q, 4'h0};
        RIG_OFF_STS: rdata_d = {5'h00, sts_q};
        RIG_OFF_MSK: rdata_d = {5'h00, msk_q};
        default: rdata_d = 8'h00;
      endcase
    end
  end

  always_ff @(posedge SYS_CLK) begin
    if (!RESET_N) begin
      rdata_q <= 8'h00;
    end else if (CE) begin
      rdata_q <= rdata_d;
    end
  end

  assign REG_RDATA = rdata_q;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  chk_pin_follows_flags: assert property (
    @(posedge SYS_CLK) disable iff (!RESET_N)
    IRQ_N_OE == |(flags_q & en_q))
    else $error("request pin disagrees with flags and enables");

  chk_summary_mirrors_pin: assert property (
    @(posedge SYS_CLK) disable iff (!RESET_N)
    CE && rd_flag |=> REG_RDATA[RIG_BIT_SUM] == $past(IRQ_N_OE))
    else $error("summary bit differs from pin state");

  chk_read_clears_flags: assert property (
    @(posedge SYS_CLK) disable iff (!RESET_N)
    CE && rd_flag |=> flags_q == '0 && !IRQ_N_OE)
    else $error("flag read did not clear flags");

  chk_read_posts_event: assert property (
    @(posedge SYS_CLK) disable iff (!RESET_N)
    CE && rd_flag && ALARM_MATCH ##1 CE && !rd_flag |=> flags_q.alarm)
    else $error("event during flag read was lost");

  chk_disabled_no_pin: assert property (
    @(posedge SYS_CLK) disable iff (!RESET_N)
    en_q == '0 |-> !IRQ_N_OE)
    else $error("pin driven with every source disabled");

  chk_flag_sets_anyway: assert property (
    @(posedge SYS_CLK) disable iff (!RESET_N)
    CE && UPDATE_DONE && !rd_flag |=> flags_q.update)
    else $error("update flag not set by event");

  chk_enable_asserts_now: assert property (
    @(posedge SYS_CLK) disable iff (!RESET_N)
    CE && wr_ctrl && REG_REQ.wdata[RIG_BIT_PIE] && flags_q.periodic && !rd_flag
    |=> IRQ_N_OE)
    else $error("late enable did not assert pin at once");

  chk_reset_clears_all: assert property (
    @(posedge SYS_CLK) disable iff (!RESET_N)
    $rose(RESET_N) |-> !IRQ_N_OE && flags_q == '0 && ctrl_q == RIG_CTRL_RST)
    else $error("reset left flags, enables or pin set");

  chk_slow_rate_tap: assert property (
    @(posedge SYS_CLK) disable iff (!RESET_N)
    per_hit && rate_q == 4'hF |-> div_q[13:0] == 14'h3FFF && TB_TICK)
    else $error("slowest periodic rate fired off its tap");

  chk_int_level: assert property (
    @(posedge SYS_CLK) disable iff (!RESET_N)
    INT_LVL == |(sts_q & msk_q))
    else $error("interrupt level disagrees with status and mask");

  chk_event_survives_reads: assert property (
    @(posedge SYS_CLK) disable iff (!RESET_N)
    CE && rd_flag && ALARM_MATCH ##1 CE && rd_flag ##1 CE && !rd_flag
    |=> flags_q.alarm)
    else $error("event held over back to back reads was lost");

  chk_set_blocks_update: assert property (
    @(posedge SYS_CLK) disable iff (!RESET_N)
    ctrl_q[RIG_BIT_SET] && !ctrl_q[RIG_BIT_PIE] && !ctrl_q[RIG_BIT_AIE] |-> !IRQ_N_OE)
    else $error("update request passed while SET was high");

  chk_pin_rises_event: assert property (
    @(posedge SYS_CLK) disable iff (!RESET_N)
    CE && ALARM_MATCH && en_d.alarm && !rd_flag |=> IRQ_N_OE)
    else $error("enabled alarm event did not drive the pin");

  chk_idle_rdata_zero: assert property (
    @(posedge SYS_CLK) disable iff (!RESET_N)
    CE && !REG_REQ.rd |=> REG_RDATA == 8'h00)
    else $error("read data not zero outside a read");

  chk_status_set_wins: assert property (
    @(posedge SYS_CLK) disable iff (!RESET_N)
    CE && ALARM_MATCH |=> sts_q[1])
    else $error("alarm event did not set system status");

  chk_status_w1c: assert property (
    @(posedge SYS_CLK) disable iff (!RESET_N)
    CE && wr_sts && REG_REQ.wdata[1] && !ALARM_MATCH |=> !sts_q[1])
    else $error("write one did not clear system status");

  chk_ce_freezes_state: assert property (
    @(posedge SYS_CLK) disable iff (!RESET_N)
    !CE |=> $stable(flags_q) && $stable(ctrl_q) && $stable(IRQ_N_OE))
    else $error("state moved while clock enable was low");

  chk_alias_rate_tap: assert property (
    @(posedge SYS_CLK) disable iff (!RESET_N)
    per_hit && rate_q == 4'h1 |-> div_q[6:0] == 7'h7F && TB_TICK)
    else $error("rate one fired off its tap");

endmodule : rig_top

// ---- hdl/rig_pkg.sv ----
package rig_pkg;

  // ----------------------------------------------------------------
  // Register offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] RIG_OFF_RATE = 8'h0A;
  localparam logic [7:0] RIG_OFF_CTRL = 8'h0B;
  localparam logic [7:0] RIG_OFF_FLAG = 8'h0C;
  localparam logic [7:0] RIG_OFF_STS = 8'h10;
  localparam logic [7:0] RIG_OFF_MSK = 8'h11;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int RIG_BIT_SET = 7;
  localparam int RIG_BIT_PIE = 6;
  localparam int RIG_BIT_AIE = 5;
  localparam int RIG_BIT_UIE = 4;
  localparam int RIG_BIT_SUM = 7;
  localparam int RIG_FLAG_LSB = 4;

  // ----------------------------------------------------------------
  // Reset values and divider figures
  // ----------------------------------------------------------------
  localparam logic [3:0] RIG_RATE_RST = 4'h0;
  localparam logic [7:0] RIG_CTRL_RST = 8'h00;
  localparam logic [2:0] RIG_MSK_RST = 3'h0;
  localparam int RIG_DIV_W = 15;
  localparam logic [3:0] RIG_TAP_RATE1 = 4'h7;
  localparam logic [3:0] RIG_TAP_RATE2 = 4'h8;

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef struct packed {
    logic periodic;
    logic alarm;
    logic update;
  } rig_ev_t;

  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } rig_req_t;

endpackage : rig_pkg

// ---- test/rig_host.sv ----
`timescale 1ns/1ns
module rig_host (
  // Open-drain request pin of the device
  input wire logic irq_n_o,
  input wire logic irq_n_oe,
  // Level seen at the host interrupt input
  output logic irq_pin_n
);
  // A released pin is pulled high by the external resistor
  assign irq_pin_n = irq_n_oe ? irq_n_o : 1'b1;
endmodule : rig_host

// ---- test/tb.sv ----
`timescale 1ns/1ns
module tb;
  import rig_pkg::*;
  logic sys_clk, reset_n, tick, alarm, upd, irq_o, irq_oe, int_lvl, irq_pin_n, ce;
  rig_req_t req;
  logic [7:0] rdata;
  int n_mismatch = 0;
  int checked = 0;
  int cyc = 0;
  logic [7:0] en_bit [3] = '{8'h40, 8'h20, 8'h10};

  rig_top dut (.SYS_CLK(sys_clk), .RESET_N(reset_n), .CE(ce), .REG_REQ(req),
    .REG_RDATA(rdata), .TB_TICK(tick), .ALARM_MATCH(alarm), .UPDATE_DONE(upd),
    .IRQ_N_O(irq_o), .IRQ_N_OE(irq_oe), .INT_LVL(int_lvl));
  rig_host host (.irq_n_o(irq_o), .irq_n_oe(irq_oe), .irq_pin_n(irq_pin_n));

  initial begin
    sys_clk = 1'b0;
    forever #2 sys_clk = ~sys_clk;
  end

  task automatic give_verdict();
    $display("mismatches %0d, comparisons %0d", n_mismatch, checked);
    if (n_mismatch == 0 && checked > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : give_verdict

  // Ceiling: the slowest periodic run takes 16384 ticks, the rest a few hundred cycles
  always @(posedge sys_clk) begin
    cyc <= cyc + 1;
    if (cyc == 40000) begin
      n_mismatch++;
      give_verdict();
    end
  end

  task automatic chk(input string name, input logic [7:0] exp, input logic [7:0] got);
    checked++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[FAIL] %s expected %h seen %h", name, exp, got);
    end
  endtask : chk

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge sys_clk);
    req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge sys_clk);
    req.wr <= 1'b0;
    #1;
  endtask : wr

  // Read data stand only in the cycle after the strobe
  task automatic rd(input logic [7:0] a, input logic [7:0] exp, input string name);
    @(posedge sys_clk);
    req <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
    @(posedge sys_clk);
    req.rd <= 1'b0;
    #1;
    chk(name, exp, rdata);
  endtask : rd

  task automatic pulse(input int src);
    @(posedge sys_clk);
    tick <= (src == 0);
    alarm <= (src == 1);
    upd <= (src == 2);
    @(posedge sys_clk);
    tick <= 1'b0;
    alarm <= 1'b0;
    upd <= 1'b0;
    #1;
  endtask : pulse

  // A full period of ticks at rate r holds one periodic event; then enable it late
  task automatic rate_run(input logic [7:0] r, input int n, input logic [7:0] exp);
    wr(RIG_OFF_RATE, r);
    @(posedge sys_clk);
    tick <= 1'b1;
    repeat (n) @(posedge sys_clk);
    tick <= 1'b0;
    #1;
    wr(RIG_OFF_CTRL, exp);
    chk("pin on late enable", {7'h00, !exp[6]}, {7'h00, irq_pin_n});
    rd(RIG_OFF_FLAG, {exp[6], exp[6:0]}, "periodic rate");
  endtask : rate_run

  initial begin
    reset_n = 1'b0;
    req = '0;
    tick = 1'b0;
    alarm = 1'b0;
    upd = 1'b0;
    ce = 1'b1;
    repeat (10) @(posedge sys_clk);
    reset_n <= 1'b1;
    rd(RIG_OFF_CTRL, 8'h00, "ctrl after reset");
    rd(RIG_OFF_FLAG, 8'h00, "flags after reset");
    chk("pin after reset", 8'h01, {7'h00, irq_pin_n});
    // Polling: flags set with every enable off, pin stays released
    pulse(1);
    pulse(2);
    chk("pin disabled", 8'h01, {7'h00, irq_pin_n});
    rd(RIG_OFF_FLAG, 8'h30, "polled flags");
    rd(RIG_OFF_FLAG, 8'h00, "flags cleared");
    // Stale flag asserts the pin as soon as it is enabled
    pulse(1);
    wr(RIG_OFF_CTRL, 8'h20);
    chk("pin on enable", 8'h00, {7'h00, irq_pin_n});
    rd(RIG_OFF_FLAG, 8'hA0, "summary flags");
    chk("pin after read", 8'h01, {7'h00, irq_pin_n});
    // Each source alone; rate 3 gives a periodic event every four ticks
    wr(RIG_OFF_RATE, 8'h03);
    rd(RIG_OFF_RATE, 8'h03, "rate readback");
    for (int i = 0; i < 3; i++) begin
      wr(RIG_OFF_CTRL, en_bit[i]);
      rd(RIG_OFF_FLAG, 8'h00, "stale cleared");
      repeat ((i == 0) ? 8 : 1) pulse(i);
      chk("pin per source", 8'h00, {7'h00, irq_pin_n});
      rd(RIG_OFF_FLAG, 8'h80 | en_bit[i], "source flags");
      if (i == 0) begin
        wr(RIG_OFF_RATE, 8'h00);
      end
    end
    // Update source is held back while SET freezes the user copy
    wr(RIG_OFF_CTRL, 8'h90);
    rd(RIG_OFF_CTRL, 8'h90, "ctrl readback");
    pulse(2);
    chk("pin while set", 8'h01, {7'h00, irq_pin_n});
    rd(RIG_OFF_FLAG, 8'h10, "update flag while set");
    // Event in the read cycle is held and posted afterwards, also past a second read
    wr(RIG_OFF_CTRL, 8'h00);
    for (int n = 1; n <= 2; n++) begin
      @(posedge sys_clk);
      req <= '{addr: RIG_OFF_FLAG, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
      alarm <= 1'b1;
      @(posedge sys_clk);
      alarm <= 1'b0;
      if (n == 2) begin
        #1;
        chk("read beside event", 8'h00, rdata);
        @(posedge sys_clk);
      end
      req.rd <= 1'b0;
      #1;
      chk("read beside event", 8'h00, rdata);
      rd(RIG_OFF_FLAG, 8'h20, "posted flag");
    end
    // System status, mask and clear-by-one; status left by earlier events goes first
    wr(RIG_OFF_STS, 8'h07);
    wr(RIG_OFF_MSK, 8'h07);
    rd(RIG_OFF_MSK, 8'h07, "mask readback");
    pulse(1);
    chk("int level", 8'h01, {7'h00, int_lvl});
    rd(RIG_OFF_STS, 8'h02, "status alarm");
    wr(RIG_OFF_STS, 8'h02);
    chk("int cleared", 8'h00, {7'h00, int_lvl});
    wr(RIG_OFF_MSK, 8'h00);
    pulse(2);
    chk("int masked", 8'h00, {7'h00, int_lvl});
    rd(RIG_OFF_STS, 8'h01, "status masked");
    wr(RIG_OFF_STS, 8'h07);
    rd(RIG_OFF_FLAG, 8'h30, "flags before ro write");
    wr(RIG_OFF_FLAG, 8'hFF);
    rd(RIG_OFF_FLAG, 8'h00, "read-only flags");
    rd(8'h20, 8'h00, "unmapped");
    // Periodic taps: none at rate 0, aliased slow taps at 1 and 2, slowest at 15
    rate_run(8'h00, 16, 8'h00);
    rate_run(8'h01, 128, 8'h40);
    rate_run(8'h02, 256, 8'h40);
    rate_run(8'h0F, 16384, 8'h40);
    // A low clock enable drops strobes and events alike
    @(posedge sys_clk);
    ce <= 1'b0;
    pulse(1);
    wr(RIG_OFF_CTRL, 8'h00);
    @(posedge sys_clk);
    ce <= 1'b1;
    rd(RIG_OFF_CTRL, 8'h40, "ctrl frozen");
    rd(RIG_OFF_FLAG, 8'h00, "flags frozen");
    // Reset in mid-run drops a live request
    wr(RIG_OFF_CTRL, 8'h20);
    pulse(1);
    chk("pin before reset", 8'h00, {7'h00, irq_pin_n});
    @(posedge sys_clk);
    reset_n <= 1'b0;
    repeat (2) @(posedge sys_clk);
    #1;
    chk("pin in reset", 8'h01, {7'h00, irq_pin_n});
    @(posedge sys_clk);
    reset_n <= 1'b1;
    rd(RIG_OFF_CTRL, 8'h00, "ctrl after reset");
    rd(RIG_OFF_FLAG, 8'h00, "flags after reset");
    give_verdict();
  end
endmodule : tb
